// ---- pdmc_chk.sv ----
`timescale 1ns/1ps
// Watches mode changes and clock enable gating at the controller ports
module pdmc_chk (
    input wire logic                              ref_clk_i,
    input wire logic                              rstn_i,
    input wire logic                              sub_osc_i,
    input wire logic                              wakeup_i,
    input wire logic                              wakeup_en_i,
    input wire logic                              mode_req_i,
    input wire pdmc_pkg::pdmc_mode_t              mode_sel_i,
    input wire logic [2:0]                        sys_div_sel_i,
    input wire logic [1:0]                        sub_div_sel_i,
    input wire logic [pdmc_pkg::NUM_MODULES-1:0]  module_stby_i,
    input wire logic                              cpu_clk_en_o,
    input wire logic [pdmc_pkg::NUM_MODULES-1:0]  periph_clk_en_o,
    input wire pdmc_pkg::pdmc_mode_t              mode_o
);
    // Outputs stay quiet while the synced reset lags the pin, so the pin is a safe disable
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rstn_i);

    // Enables lag the mode by one edge, hence the previous mode is checked too
    a_stby_dark: assert property ($past(mode_o) == 3'h4 && mode_o == 3'h4 |->
        !cpu_clk_en_o && periph_clk_en_o == '0) else $error("enable seen in standby");
    a_stby_mask: assert property ($stable(module_stby_i) |->
        (periph_clk_en_o & module_stby_i) == '0) else $error("halted module still clocked");
    a_req_taken: assert property (
        mode_req_i && mode_o inside {3'h0, 3'h1} && mode_sel_i <= 3'h4
        |=> mode_o == $past(mode_sel_i)) else $error("mode request not taken");
    a_code_refused: assert property (
        mode_req_i && mode_o inside {3'h0, 3'h1} && mode_sel_i > 3'h4 |=> $stable(mode_o))
        else $error("undefined mode code taken");
    a_wake_return: assert property (
        (wakeup_i && wakeup_en_i && mode_o inside {3'h2, 3'h3, 3'h4})[*3]
        |=> mode_o == ($past(mode_o) == 3'h3 ? 3'h1 : 3'h0)) else $error("wake did not return");
    a_wake_masked: assert property (mode_o inside {3'h2, 3'h3, 3'h4} && !wakeup_en_i
        |=> $stable(mode_o)) else $error("disabled wake left low power mode");
    a_div1_rate: assert property (
        (mode_o == 3'h0 && sys_div_sel_i == 3'h0)[*5] |-> cpu_clk_en_o)
        else $error("undivided clock missed a cycle");
    a_halt_cpu: assert property (
        $past(mode_o) inside {3'h2, 3'h3} && mode_o inside {3'h2, 3'h3}
        |-> !cpu_clk_en_o) else $error("cpu clocked while halted");

    c_sleep: cover property (mode_o == 3'h2 ##1 mode_o == 3'h0);
    c_subsleep: cover property (mode_o == 3'h3 ##1 mode_o == 3'h1);
    c_standby: cover property (mode_o == 3'h4 ##1 mode_o == 3'h0);
endmodule

bind pdmc_top pdmc_chk pdmc_chk_inst (.*);

// ---- pdmc_pkg.sv ----
package pdmc_pkg;

    // Operating states, also reported on the mode output
    typedef enum logic [2:0] {
        PDMC_ACTIVE    = 3'h0,
        PDMC_SUBACTIVE = 3'h1,
        PDMC_SLEEP     = 3'h2,
        PDMC_SUBSLEEP  = 3'h3,
        PDMC_STANDBY   = 3'h4
    } pdmc_mode_t;

    // Number of peripheral modules with their own clock enable
    localparam int unsigned NUM_MODULES = 8;

    // System clock divider selection codes and their masks
    localparam logic [2:0] SYS_DIV1_SEL  = 3'h0;
    localparam logic [2:0] SYS_DIV8_SEL  = 3'h1;
    localparam logic [2:0] SYS_DIV16_SEL = 3'h2;
    localparam logic [2:0] SYS_DIV32_SEL = 3'h3;
    localparam logic [2:0] SYS_DIV64_SEL = 3'h4;
    localparam logic [5:0] SYS_DIV1_MASK  = 6'h00;
    localparam logic [5:0] SYS_DIV8_MASK  = 6'h07;
    localparam logic [5:0] SYS_DIV16_MASK = 6'h0F;
    localparam logic [5:0] SYS_DIV32_MASK = 6'h1F;
    localparam logic [5:0] SYS_DIV64_MASK = 6'h3F;

    // Subclock divider selection codes and their masks on the edge counter
    localparam logic [1:0] SUB_DIV2_SEL  = 2'h0;
    localparam logic [1:0] SUB_DIV4_SEL  = 2'h1;
    localparam logic [1:0] SUB_DIV8_SEL  = 2'h2;
    localparam logic [2:0] SUB_DIV2_MASK = 3'h1;
    localparam logic [2:0] SUB_DIV4_MASK = 3'h3;
    localparam logic [2:0] SUB_DIV8_MASK = 3'h7;

    // Reset values
    localparam logic [5:0] SYS_CNT_RST = 6'h00;
    localparam logic [2:0] SUB_CNT_RST = 3'h0;

endpackage

// ---- pdmc_top.sv ----
`timescale 1ns/1ps
// Behaviour
// - Five operating modes plus per-module standby are available after reset.
// - Active: CPU and peripherals tick on oscillator clock divided 1, 8, 16, 32 or 64.
// - Subactive: CPU and peripherals tick on subclock divided by 2, 4 or 8.
// - Sleep: CPU clock stops, peripherals keep the system clock.
// - Subsleep: CPU clock stops, peripherals keep the subclock.
// - Standby: CPU and all peripherals lose every clock.
// - Module standby stops only selected peripherals, independent of the mode.
module pdmc_top (
    input  wire logic                            ref_clk_i,
    input  wire logic                            rstn_i,
    input  wire logic                            sub_osc_i,
    input  wire logic                            wakeup_i,
    input  wire logic                            wakeup_en_i,
    input  wire logic                            mode_req_i,
    input  wire pdmc_pkg::pdmc_mode_t            mode_sel_i,
    input  wire logic [2:0]                      sys_div_sel_i,
    input  wire logic [1:0]                      sub_div_sel_i,
    input  wire logic [pdmc_pkg::NUM_MODULES-1:0] module_stby_i,
    output logic                                 cpu_clk_en_o,
    output logic [pdmc_pkg::NUM_MODULES-1:0]     periph_clk_en_o,
    output pdmc_pkg::pdmc_mode_t                 mode_o
);

    logic                 rst_s1_q;
    logic                 rst_sync_n_q;
    logic                 sub_s1_q;
    logic                 sub_s2_q;
    logic                 sub_s3_q;
    logic                 wake_s1_q;
    logic                 wake_s2_q;
    logic [5:0]           sys_cnt_q;
    logic [2:0]           sub_cnt_q;
    pdmc_pkg::pdmc_mode_t state_q;
    pdmc_pkg::pdmc_mode_t state_d;
    logic                 cpu_en_q;
    logic [pdmc_pkg::NUM_MODULES-1:0] per_en_q;

    // Reset released through two flops so every flop leaves reset on the same edge
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rst_s1_q     <= 1'h0;
            rst_sync_n_q <= 1'h0;
        end
        else
        begin
            rst_s1_q     <= 1'h1;
            rst_sync_n_q <= rst_s1_q;
        end
    end

    // Pin synchronisers; the third subclock stage only feeds the edge detector
    always_ff @(posedge ref_clk_i or negedge rst_sync_n_q)
    begin
        if (!rst_sync_n_q)
        begin
            sub_s1_q  <= 1'h0;
            sub_s2_q  <= 1'h0;
            sub_s3_q  <= 1'h0;
            wake_s1_q <= 1'h0;
            wake_s2_q <= 1'h0;
        end
        else
        begin
            sub_s1_q  <= sub_osc_i;
            sub_s2_q  <= sub_s1_q;
            sub_s3_q  <= sub_s2_q;
            wake_s1_q <= wakeup_i;
            wake_s2_q <= wake_s1_q;
        end
    end

    // Divider masks; an unlisted code falls back to the slowest rate
    logic [5:0] sys_mask;
    logic [2:0] sub_mask;
    assign sys_mask = (sys_div_sel_i == pdmc_pkg::SYS_DIV1_SEL)  ? pdmc_pkg::SYS_DIV1_MASK  :
                      (sys_div_sel_i == pdmc_pkg::SYS_DIV8_SEL)  ? pdmc_pkg::SYS_DIV8_MASK  :
                      (sys_div_sel_i == pdmc_pkg::SYS_DIV16_SEL) ? pdmc_pkg::SYS_DIV16_MASK :
                      (sys_div_sel_i == pdmc_pkg::SYS_DIV32_SEL) ? pdmc_pkg::SYS_DIV32_MASK :
                                                                   pdmc_pkg::SYS_DIV64_MASK;
    assign sub_mask = (sub_div_sel_i == pdmc_pkg::SUB_DIV2_SEL) ? pdmc_pkg::SUB_DIV2_MASK :
                      (sub_div_sel_i == pdmc_pkg::SUB_DIV4_SEL) ? pdmc_pkg::SUB_DIV4_MASK :
                                                                  pdmc_pkg::SUB_DIV8_MASK;

    // Tick enables standing in for the divided clocks; no gated clock is built
    logic sub_edge;
    logic sys_tick;
    logic sub_tick;
    assign sub_edge = sub_s2_q & ~sub_s3_q;
    assign sys_tick = ((sys_cnt_q & sys_mask) == sys_mask);
    assign sub_tick = sub_edge & ((sub_cnt_q & sub_mask) == sub_mask);

    // System divider runs free; a select change may stretch one period only
    always_ff @(posedge ref_clk_i or negedge rst_sync_n_q)
    begin
        if (!rst_sync_n_q)
        begin
            sys_cnt_q <= pdmc_pkg::SYS_CNT_RST;
        end
        else
        begin
            sys_cnt_q <= sys_cnt_q + 6'h01;
        end
    end

    // Subclock edges are counted, so one slow edge never yields two ticks
    always_ff @(posedge ref_clk_i or negedge rst_sync_n_q)
    begin
        if (!rst_sync_n_q)
        begin
            sub_cnt_q <= pdmc_pkg::SUB_CNT_RST;
        end
        else if (sub_edge)
        begin
            sub_cnt_q <= sub_cnt_q + 3'h1;
        end
    end

    // Mode decode
    logic on_sub;
    logic cpu_runs;
    logic per_runs;
    logic wake;
    assign on_sub   = (state_q == pdmc_pkg::PDMC_SUBACTIVE) ||
                      (state_q == pdmc_pkg::PDMC_SUBSLEEP);
    assign cpu_runs = (state_q == pdmc_pkg::PDMC_ACTIVE) ||
                      (state_q == pdmc_pkg::PDMC_SUBACTIVE);
    assign per_runs = (state_q != pdmc_pkg::PDMC_STANDBY);
    assign wake     = wake_s2_q & wakeup_en_i;

    // Mode sequencer; requests are only heard while the CPU runs
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            pdmc_pkg::PDMC_ACTIVE,
            pdmc_pkg::PDMC_SUBACTIVE:
            begin
                if (mode_req_i)
                begin
                    state_d = mode_sel_i;
                end
            end
            pdmc_pkg::PDMC_SLEEP,
            pdmc_pkg::PDMC_STANDBY:
            begin
                if (wake)
                begin
                    state_d = pdmc_pkg::PDMC_ACTIVE;
                end
            end
            pdmc_pkg::PDMC_SUBSLEEP:
            begin
                if (wake)
                begin
                    state_d = pdmc_pkg::PDMC_SUBACTIVE;
                end
            end
            default:
            begin
                state_d = pdmc_pkg::PDMC_ACTIVE;
            end
        endcase
    end

    // Undefined requested codes are refused so the state stays legal
    pdmc_pkg::pdmc_mode_t state_chk;
    assign state_chk = (state_d > pdmc_pkg::PDMC_STANDBY) ? state_q : state_d;

    // Clock enable selection per consumer
    logic                             base_tick;
    logic [pdmc_pkg::NUM_MODULES-1:0] per_en_d;
    assign base_tick = on_sub ? sub_tick : sys_tick;
    assign per_en_d  = {pdmc_pkg::NUM_MODULES{per_runs & base_tick}}
                       & ~module_stby_i;

    // Mode register; an illegal request never reaches it
    always_ff @(posedge ref_clk_i or negedge rst_sync_n_q)
    begin
        if (!rst_sync_n_q)
        begin
            state_q <= pdmc_pkg::PDMC_ACTIVE;
        end
        else
        begin
            state_q <= state_chk;
        end
    end

    // CPU enable; registered so the pulse leaves the block glitch free
    always_ff @(posedge ref_clk_i or negedge rst_sync_n_q)
    begin
        if (!rst_sync_n_q)
        begin
            cpu_en_q <= 1'h0;
        end
        else
        begin
            cpu_en_q <= cpu_runs & base_tick;
        end
    end

    // Peripheral enables; a standby change takes effect one edge later
    always_ff @(posedge ref_clk_i or negedge rst_sync_n_q)
    begin
        if (!rst_sync_n_q)
        begin
            per_en_q <= '0;
        end
        else
        begin
            per_en_q <= per_en_d;
        end
    end

    assign cpu_clk_en_o    = cpu_en_q;
    assign periph_clk_en_o = per_en_q;
    assign mode_o          = state_q;

endmodule

// ---- test_pdmc_top.sv ----
`timescale 1ns/1ps
module test_pdmc_top;
    logic                                ref_clk_i, rstn_i, sub_osc_i, wakeup_i, wakeup_en_i;
    logic                                mode_req_i, cpu_clk_en_o;
    logic [2:0]                          sys_div_sel_i, cur;
    logic [1:0]                          sub_div_sel_i;
    logic [pdmc_pkg::NUM_MODULES-1:0]    module_stby_i, periph_clk_en_o, m, acc;
    pdmc_pkg::pdmc_mode_t                mode_sel_i, mode_o;
    pdmc_pkg::pdmc_mode_t                exp_q[$];
    int                                  mismatches, comparisons, cyc, c, p;
    int                                  sd[8] = '{1, 8, 16, 32, 64, 64, 64, 64};
    int                                  wd[4] = '{2, 4, 8, 8};

    pdmc_top pdmc_top_inst (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .sub_osc_i(sub_osc_i),
        .wakeup_i(wakeup_i), .wakeup_en_i(wakeup_en_i), .mode_req_i(mode_req_i),
        .mode_sel_i(mode_sel_i), .sys_div_sel_i(sys_div_sel_i), .sub_div_sel_i(sub_div_sel_i),
        .module_stby_i(module_stby_i), .cpu_clk_en_o(cpu_clk_en_o),
        .periph_clk_en_o(periph_clk_en_o), .mode_o(mode_o));

    initial
    begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end

    // Subclock rises every 6 cycles; cycle ceiling cuts a hang short
    always @(negedge ref_clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc % 3 == 0) sub_osc_i <= ~sub_osc_i;
        if (cyc == 6000)
        begin
            mismatches++;
            conclude();
        end
    end

    // Every mode change while rstn_i is high must match the oldest noted expectation
    // A change with no note pending is itself a mismatch
    always @(mode_o)
    begin
        if (rstn_i === 1'b1 && exp_q.size() == 0)
            check(8'hFF, mode_o);
        else if (rstn_i === 1'b1)
            check(mode_o, exp_q.pop_front());
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic req(input logic [2:0] s, input logic ok);
        mode_sel_i = pdmc_pkg::pdmc_mode_t'(s);
        mode_req_i = 1'b1;
        if (ok) exp_q.push_back(pdmc_pkg::pdmc_mode_t'(s));
        if (ok) cur = s;
        @(negedge ref_clk_i);
        mode_req_i = 1'b0;
        repeat (8) @(negedge ref_clk_i);
        check(mode_o, cur);
    endtask

    // Wake first with the enable low, which must be ignored, then in earnest;
    // the enable rises only once the synced pin has fallen, else a stale wake fires
    task automatic wake(input logic [2:0] s);
        wakeup_i = 1'b1;
        repeat (6) @(negedge ref_clk_i);
        check(mode_o, cur);
        wakeup_i = 1'b0;
        repeat (4) @(negedge ref_clk_i);
        wakeup_en_i = 1'b1;
        exp_q.push_back(pdmc_pkg::pdmc_mode_t'(s));
        cur = s;
        wakeup_i = 1'b1;
        repeat (6) @(negedge ref_clk_i);
        wakeup_i = 1'b0;
        wakeup_en_i = 1'b0;
        check(mode_o, cur);
    endtask

    // Counts cpu ticks, ticks of any live module, and which modules ever ticked
    task automatic meas(input int n, input int ec, input int ep, input logic [7:0] ea);
        c = 0;
        p = 0;
        acc = '0;
        repeat (16) @(negedge ref_clk_i);
        repeat (n)
        begin
            @(negedge ref_clk_i);
            c += (cpu_clk_en_o === 1'b1);
            p += ((|(periph_clk_en_o & ~module_stby_i)) === 1'b1);
            acc |= periph_clk_en_o;
        end
        check(c[7:0], ec[7:0]);
        check(p[7:0], ep[7:0]);
        check(acc, ea);
    endtask

    task automatic conclude();
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        {rstn_i, sub_osc_i, wakeup_i, wakeup_en_i, mode_req_i, cur} = '0;
        {sys_div_sel_i, sub_div_sel_i, module_stby_i, mismatches, comparisons, cyc} = '0;
        mode_sel_i = pdmc_pkg::PDMC_ACTIVE;
        void'($urandom(41410));
        repeat (20) @(negedge ref_clk_i);
        rstn_i = 1'b1;
        repeat (4) @(negedge ref_clk_i);
        m = 8'($urandom) & 8'hFE;
        module_stby_i = m;
        // Codes past the listed ones fall back to the slowest rate
        foreach (sd[i])
        begin
            sys_div_sel_i = i[2:0];
            meas(64, 64 / sd[i], 64 / sd[i], ~m);
        end
        req(3'h1, 1'b1);
        foreach (wd[i])
        begin
            sub_div_sel_i = i[1:0];
            meas(96, 96 / (6 * wd[i]), 96 / (6 * wd[i]), ~m);
        end
        req(3'h5, 1'b0);
        req(3'h3, 1'b1);
        meas(96, 0, 2, ~m);
        req(3'h0, 1'b0);
        wake(3'h1);
        req(3'h0, 1'b1);
        sys_div_sel_i = 3'h1;
        req(3'h2, 1'b1);
        meas(64, 0, 8, ~m);
        wake(3'h0);
        req(3'h4, 1'b1);
        meas(64, 0, 0, 8'h00);
        wake(3'h0);
        // Reset in mid-run must also bring standby back to active
        req(3'h4, 1'b1);
        rstn_i = 1'b0;
        repeat (3) @(negedge ref_clk_i);
        cur = 3'h0;
        check(mode_o, cur);
        rstn_i = 1'b1;
        repeat (4) @(negedge ref_clk_i);
        meas(64, 8, 8, ~m);
        check(8'(exp_q.size()), 8'h00);
        conclude();
    end
endmodule
